// ==== rtl/level_setpoint_params.svh ====
// Function
// - Thirty-two level comparators, each with own output
// - Unused source disables level, holds state
// - Net or gross source ignores display state
// - Displayed source follows scale net/gross state
// - Flow source usable only with flow enabled
// - Absolute sources compare signal magnitude
// - Level scale setting selects scale one-eight
// - Polarity makes output active above or below
// - Thresholds: level and level plus hysteresis
// - Level status readable, independent of outputs
// - Sixteen one-shot setpoints, armed, self-disarming
// - Setpoint source and scale select weight
// - Arming asserts connected setpoint output
// - Exceeding weight disarms, flags done, drops output
// - Cancel disarms and drops connected output
// - Done cleared on value load and arming
// - Any armed setpoint inhibits zero-tracking
`ifndef LEVEL_SETPOINT_PARAMS_SVH
`define LEVEL_SETPOINT_PARAMS_SVH

// Sizes
`define N_LVL      32
`define N_SP       16
`define N_SCALE    8
`define SCALE_W    3
`define WW         24
`define CW         26
`define DW         32
`define AW         12
`define CFG_W      10

// Source codes
`define SRC_UNUSED 4'h0
`define SRC_NET    4'h1
`define SRC_GROSS  4'h2
`define SRC_DISP   4'h3
`define SRC_FLOW   4'h4
`define SRC_ANET   4'h5
`define SRC_AGROSS 4'h6
`define SRC_ADISP  4'h7
`define SRC_AFLOW  4'h8

// Configuration word fields
`define F_SRC      3:0
`define F_SCALE    6:4
`define F_POL      8
`define F_CONN     9

// Register map, byte addresses
`define A_LVL_STAT 12'h000
`define A_SP_ARMED 12'h004
`define A_SP_DONE  12'h008
`define A_SP_ARM   12'h00C
`define A_SP_CANC  12'h010
`define LPAGE      11:7
`define SPAGE      11:6
`define LIX        6:2
`define SIX        5:2
`define PG_LVAL    5'h02
`define PG_LHYS    5'h03
`define PG_LCFG    5'h04
`define PG_SVAL    6'h0A
`define PG_SCFG    6'h0B

// Reset value of all state
`define RST_STATE  '0

`endif

// ==== rtl/level_setpoint_pkg.sv ====
`include "level_setpoint_params.svh"

package level_setpoint_pkg;

	// One scale's sample bundle
	typedef struct packed {
		logic signed [`WW-1:0] net;
		logic signed [`WW-1:0] gross;
		logic signed [`WW-1:0] flow;
		logic                  disp_net;
		logic                  flow_en;
		logic                  sample;
	} scale_in_t;

	// APB request from the master
	typedef struct packed {
		logic           psel;
		logic           penable;
		logic           pwrite;
		logic [`AW-1:0] paddr;
		logic [`DW-1:0] pwdata;
	} apb_req_t;

	// Whole block state
	typedef struct packed {
		logic [`N_LVL-1:0][`WW-1:0]    lval;
		logic [`N_LVL-1:0][`WW-1:0]    lhys;
		logic [`N_LVL-1:0][`CFG_W-1:0] lcfg;
		logic [`N_LVL-1:0]             lstat;
		logic [`N_LVL-1:0]             lout;
		logic [`N_SP-1:0][`WW-1:0]     sval;
		logic [`N_SP-1:0][`CFG_W-1:0]  scfg;
		logic [`N_SP-1:0]              armed;
		logic [`N_SP-1:0]              done;
		logic [`N_SP-1:0]              spout;
		logic                          zinh;
		logic                          pready;
		logic                          pslverr;
		logic [`DW-1:0]                prdata;
	} state_t;

endpackage

// ==== rtl/level_setpoint_supervisor.sv ====
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "level_setpoint_params.svh"

module level_setpoint_supervisor
	import level_setpoint_pkg::*;
(
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst_n,
	input  wire scale_in_t [`N_SCALE-1:0] i_scale,
	input  wire apb_req_t                 i_apb,
	output logic                          o_pready,
	output logic [`DW-1:0]                o_prdata,
	output logic                          o_pslverr,
	output logic [`N_LVL-1:0]             o_level_out,
	output logic [`N_SP-1:0]              o_setp_out,
	output logic                          o_zero_track_inhibit
);

	state_t st_reg;
	state_t st_next;

	// Weight picked for a comparator, widened so abs and sums never wrap
	function automatic logic signed [`CW-1:0] pick(
		input logic [3:0] src,
		input scale_in_t  s
	);
		logic signed [`CW-1:0] n;
		logic signed [`CW-1:0] g;
		logic signed [`CW-1:0] f;
		logic signed [`CW-1:0] d;
		n = `CW'(s.net);
		g = `CW'(s.gross);
		f = `CW'(s.flow);
		d = s.disp_net ? n : g;
		case (src)
			`SRC_NET:    pick = n;
			`SRC_GROSS:  pick = g;
			`SRC_DISP:   pick = d;
			`SRC_FLOW:   pick = f;
			`SRC_ANET:   pick = (n < 0) ? -n : n;
			`SRC_AGROSS: pick = (g < 0) ? -g : g;
			`SRC_ADISP:  pick = (d < 0) ? -d : d;
			`SRC_AFLOW:  pick = (f < 0) ? -f : f;
			default:     pick = '0;
		endcase
	endfunction

	// Source usable: defined, not unused, flow only with flow enabled
	function automatic logic usable(
		input logic [3:0] src,
		input scale_in_t  s
	);
		logic fl;
		fl = (src == `SRC_FLOW) || (src == `SRC_AFLOW);
		usable = (src != `SRC_UNUSED) && (src <= `SRC_AFLOW)
			&& !(fl && !s.flow_en);
	endfunction

	logic [`N_LVL-1:0] lvl_upd;
	logic [`N_LVL-1:0] lvl_above;
	logic [`N_LVL-1:0] lvl_drive;
	logic [`N_SP-1:0]  sp_hit;
	logic [`N_SP-1:0]  sp_conn;

	// Per-level comparator
	for (genvar i = 0; i < `N_LVL; i++) begin : g_lvl
		scale_in_t             s;
		logic signed [`CW-1:0] sig;
		logic signed [`CW-1:0] lv;
		logic signed [`CW-1:0] th2;
		logic signed [`CW-1:0] hi;
		logic signed [`CW-1:0] lo;
		logic                  above;

		assign s = i_scale[st_reg.lcfg[i][`F_SCALE]];
		assign sig = pick(st_reg.lcfg[i][`F_SRC], s);
		assign lv = `CW'($signed(st_reg.lval[i]));
		assign th2 = lv + `CW'($signed(st_reg.lhys[i]));
		// Band edges swap with the hysteresis sign
		assign hi = (st_reg.lhys[i][`WW-1]) ? lv : th2;
		assign lo = (st_reg.lhys[i][`WW-1]) ? th2 : lv;
		// Held state decides which edge is live
		assign above = st_reg.lstat[i] ? !(sig < lo) : (sig > hi);
		assign lvl_above[i] = above;
		// Only a fresh sample on its own scale moves a level
		assign lvl_upd[i] = s.sample && usable(st_reg.lcfg[i][`F_SRC], s);
		assign lvl_drive[i] = st_reg.lcfg[i][`F_CONN]
			&& (st_reg.lcfg[i][`F_POL] ? !above : above);
	end

	// Per-setpoint comparator
	for (genvar j = 0; j < `N_SP; j++) begin : g_sp
		scale_in_t             s;
		logic signed [`CW-1:0] sig;
		logic signed [`CW-1:0] sv;

		assign s = i_scale[st_reg.scfg[j][`F_SCALE]];
		assign sig = pick(st_reg.scfg[j][`F_SRC], s);
		assign sv = `CW'($signed(st_reg.sval[j]));
		// Strictly higher than the setpoint ends the cycle
		assign sp_hit[j] = st_reg.armed[j] && s.sample
			&& usable(st_reg.scfg[j][`F_SRC], s) && (sig > sv);
		assign sp_conn[j] = st_reg.scfg[j][`F_CONN];
	end

	logic           acc;
	logic           wr;
	logic [`AW-1:0] a;
	logic [`DW-1:0] wd;
	logic [`DW-1:0] rdv;
	logic           map;
	logic [`N_SP-1:0] arm;
	logic [`N_SP-1:0] canc;
	logic [`N_SP-1:0] load;

	// Next state: bus decode, comparator updates, setpoint sequencing
	always_comb begin
		st_next = st_reg;
		a = i_apb.paddr;
		wd = i_apb.pwdata;
		acc = i_apb.psel && i_apb.penable;
		// Writes land only on the edge that completes the access
		wr = acc && st_reg.pready && i_apb.pwrite;
		rdv = '0;
		map = 1'b1;
		arm = '0;
		canc = '0;
		load = '0;

		// Address decode shared by read and write
		if (a[`LPAGE] == `PG_LVAL) begin
			rdv = {{(`DW-`WW){st_reg.lval[a[`LIX]][`WW-1]}}, st_reg.lval[a[`LIX]]};
			if (wr) begin
				st_next.lval[a[`LIX]] = wd[`WW-1:0];
			end
		end else if (a[`LPAGE] == `PG_LHYS) begin
			rdv = {{(`DW-`WW){st_reg.lhys[a[`LIX]][`WW-1]}}, st_reg.lhys[a[`LIX]]};
			if (wr) begin
				st_next.lhys[a[`LIX]] = wd[`WW-1:0];
			end
		end else if (a[`LPAGE] == `PG_LCFG) begin
			rdv = `DW'(st_reg.lcfg[a[`LIX]]);
			if (wr) begin
				st_next.lcfg[a[`LIX]] = wd[`CFG_W-1:0];
			end
		end else if (a[`SPAGE] == `PG_SVAL) begin
			rdv = {{(`DW-`WW){st_reg.sval[a[`SIX]][`WW-1]}}, st_reg.sval[a[`SIX]]};
			if (wr) begin
				st_next.sval[a[`SIX]] = wd[`WW-1:0];
				load[a[`SIX]] = 1'b1;
			end
		end else if (a[`SPAGE] == `PG_SCFG) begin
			rdv = `DW'(st_reg.scfg[a[`SIX]]);
			if (wr) begin
				st_next.scfg[a[`SIX]] = wd[`CFG_W-1:0];
			end
		end else begin
			case (a)
				`A_LVL_STAT: begin
					rdv = st_reg.lstat;
				end
				`A_SP_ARMED: begin
					rdv = `DW'(st_reg.armed);
				end
				`A_SP_DONE: begin
					rdv = `DW'(st_reg.done);
				end
				// Command words read back as zero
				`A_SP_ARM: begin
					if (wr) begin
						arm = wd[`N_SP-1:0];
					end
				end
				`A_SP_CANC: begin
					if (wr) begin
						canc = wd[`N_SP-1:0];
					end
				end
				default: begin
					map = 1'b0;
				end
			endcase
		end

		// Status keeps hysteresis, never the output polarity
		st_next.lstat = (st_reg.lstat & ~lvl_upd) | (lvl_above & lvl_upd);
		st_next.lout = (st_reg.lout & ~lvl_upd) | (lvl_drive & lvl_upd);

		// Arm beats a same-cycle hit or cancel of that setpoint
		st_next.armed = (st_reg.armed & ~sp_hit & ~canc) | arm;
		// A hit in the clearing cycle still leaves done set
		st_next.done = (st_reg.done & ~(arm | load)) | sp_hit;
		st_next.spout = st_next.armed & sp_conn;
		st_next.zinh = |st_next.armed;

		// One wait state: ready rises in the second access cycle
		st_next.pready = acc && !st_reg.pready;
		if (acc && !st_reg.pready) begin
			st_next.prdata = i_apb.pwrite ? '0 : rdv;
			st_next.pslverr = !map;
		end else begin
			st_next.prdata = '0;
			st_next.pslverr = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= `RST_STATE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign o_pready = st_reg.pready;
	assign o_prdata = st_reg.prdata;
	assign o_pslverr = st_reg.pslverr;
	assign o_level_out = st_reg.lout;
	assign o_setp_out = st_reg.spout;
	assign o_zero_track_inhibit = st_reg.zinh;

endmodule

// ==== tb/level_setpoint_sva.sv ====
`timescale 1ns/1ps
`include "level_setpoint_params.svh"

module level_setpoint_sva
	import level_setpoint_pkg::*;
(
	input wire logic                     i_ref_clk,
	input wire logic                     i_rst_n,
	input wire scale_in_t [`N_SCALE-1:0] i_scale,
	input wire apb_req_t                 i_apb,
	input wire logic                     o_pready,
	input wire logic [`DW-1:0]           o_prdata,
	input wire logic                     o_pslverr,
	input wire logic [`N_LVL-1:0]        o_level_out,
	input wire logic [`N_SP-1:0]         o_setp_out,
	input wire logic                     o_zero_track_inhibit
);
	logic any_smp;
	logic wr_go;
	// Any scale delivering a sample this cycle
	always_comb begin
		any_smp = 1'b0;
		for (int k = 0; k < `N_SCALE; k++) begin
			any_smp = any_smp | i_scale[k].sample;
		end
	end
	// Committed write; the only other cause of setpoint output moves
	assign wr_go = i_apb.psel & i_apb.penable & i_apb.pwrite & o_pready;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	one_wait_a: assert property ($rose(i_apb.penable) && i_apb.psel |=> o_pready)
		else $error("ready not after one wait");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("ready longer than a cycle");
	rdata_idle_a: assert property (!o_pready |-> o_prdata == '0)
		else $error("read data outside ready");
	err_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	lvl_hold_a: assert property (!any_smp |=> $stable(o_level_out))
		else $error("level output moved without sample");
	zero_inh_a: assert property (o_setp_out != '0 |-> o_zero_track_inhibit)
		else $error("zero tracking not inhibited");
	sp_rise_a: assert property ((o_setp_out & ~$past(o_setp_out)) != '0 |-> $past(wr_go))
		else $error("setpoint output rose without write");
	sp_fall_a: assert property ((~o_setp_out & $past(o_setp_out)) != '0
		|-> $past(wr_go || any_smp)) else $error("setpoint output fell without cause");
endmodule

bind level_setpoint_supervisor level_setpoint_sva u_sva (.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n), .i_scale(i_scale), .i_apb(i_apb), .o_pready(o_pready),
	.o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_level_out(o_level_out),
	.o_setp_out(o_setp_out), .o_zero_track_inhibit(o_zero_track_inhibit));

// ==== tb/remote_master.sv ====
`timescale 1ns/1ps
`include "level_setpoint_params.svh"

module remote_master
	import level_setpoint_pkg::*;
(
	input  wire logic           i_ref_clk,
	input  wire logic           i_pready,
	input  wire logic [`DW-1:0] i_prdata,
	input  wire logic           i_pslverr,
	output apb_req_t            o_apb
);
	initial o_apb = '0;
	// Values and arm commands only ever arrive through this transfer
	task automatic xfer(input logic w, input logic [`AW-1:0] a, input logic [`DW-1:0] d,
		output logic [`DW-1:0] q, output logic e, output logic to);
		int n;
		n = 0;
		@(posedge i_ref_clk);
		o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge i_ref_clk);
		o_apb.penable <= 1'b1;
		@(posedge i_ref_clk);
		// Bounded so a dead slave cannot hang the run
		while (!i_pready && n < 20) begin
			n++;
			@(posedge i_ref_clk);
		end
		to = !i_pready;
		q = i_prdata;
		e = i_pslverr;
		o_apb <= '0;
	endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "level_setpoint_params.svh"

module tb_top
	import level_setpoint_pkg::*;
;
	logic                     clk;
	logic                     rst_n;
	scale_in_t [`N_SCALE-1:0] scl;
	apb_req_t                 apb;
	logic                     pready;
	logic                     perr;
	logic [`DW-1:0]           prdata;
	logic [`N_LVL-1:0]        lvl_out;
	logic [`N_SP-1:0]         sp_out;
	logic                     zinh;
	int                       n_mismatch;
	int                       compares;

	level_setpoint_supervisor dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_scale(scl),
		.i_apb(apb), .o_pready(pready), .o_prdata(prdata), .o_pslverr(perr),
		.o_level_out(lvl_out), .o_setp_out(sp_out), .o_zero_track_inhibit(zinh));
	remote_master u_master (.i_ref_clk(clk), .i_pready(pready), .i_prdata(prdata),
		.i_pslverr(perr), .o_apb(apb));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Bus access; a lost answer ends the run at once
	task automatic acc(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] ed, logic ee);
		logic [31:0] q;
		logic        e;
		logic        to;
		u_master.xfer(w, a, d, q, e, to);
		if (to) begin
			n_mismatch++;
			end_of_test();
		end
		chk("rdata", ed, q);
		chk("slverr", {31'h0, ee}, {31'h0, e});
	endtask

	// One-cycle sample pulse, then look after the update has landed
	task automatic smp(int k, logic [23:0] nw, logic [23:0] gw);
		@(posedge clk);
		scl[k].net <= nw;
		scl[k].gross <= gw;
		scl[k].sample <= 1'b1;
		@(posedge clk);
		scl[k].sample <= 1'b0;
		@(negedge clk);
	endtask

	// Band 100..120: level 0 active above, level 1 active below
	task automatic lvl_hyst();
		acc(1, 12'h100, 32'h64, 0, 0);
		acc(1, 12'h180, 32'h14, 0, 0);
		acc(1, 12'h200, 32'h201, 0, 0);
		acc(1, 12'h104, 32'h64, 0, 0);
		acc(1, 12'h184, 32'h14, 0, 0);
		acc(1, 12'h204, 32'h301, 0, 0);
		smp(0, 24'h6E, 24'h0);
		chk("lvl inside", 32'h2, lvl_out);
		smp(0, 24'h79, 24'h0);
		chk("lvl over", 32'h1, lvl_out);
		smp(1, 24'h0, 24'h0);
		chk("lvl other scale", 32'h1, lvl_out);
		smp(0, 24'h6E, 24'h0);
		chk("lvl held", 32'h1, lvl_out);
		acc(0, 12'h000, 0, 32'h3, 0);
		smp(0, 24'h63, 24'h0);
		chk("lvl under", 32'h2, lvl_out);
	endtask

	// Level 2: abs displayed weight of scale 2, band 80..100 below the level
	// Level 3: flow of scale 2, frozen while flow is off
	task automatic lvl_src();
		acc(1, 12'h108, 32'h64, 0, 0);
		acc(1, 12'h188, 32'hFFFFFFEC, 0, 0);
		acc(0, 12'h188, 0, 32'hFFFFFFEC, 0);
		acc(1, 12'h208, 32'h227, 0, 0);
		acc(1, 12'h20C, 32'h224, 0, 0);
		scl[2].disp_net <= 1'b1;
		scl[2].flow <= 24'h5;
		smp(2, 24'hFFFF92, 24'h0);
		chk("abs net shown", 32'h6, lvl_out);
		@(posedge clk);
		scl[2].disp_net <= 1'b0;
		scl[2].flow_en <= 1'b1;
		smp(2, 24'hFFFF92, 24'h46);
		chk("gross shown", 32'hA, lvl_out);
		smp(2, 24'hFFFF92, 24'h5F);
		chk("negative band", 32'hA, lvl_out);
	endtask

	// Setpoint 0 on gross of scale 1, value 50
	task automatic setp();
		acc(1, 12'h280, 32'h32, 0, 0);
		acc(1, 12'h2C0, 32'h212, 0, 0);
		acc(1, 12'h00C, 32'h1, 0, 0);
		@(negedge clk);
		chk("armed out", 32'h1, {16'h0, sp_out});
		chk("zero inhibit", 32'h1, {31'h0, zinh});
		smp(1, 24'h0, 24'h32);
		chk("at value", 32'h1, {16'h0, sp_out});
		smp(1, 24'h0, 24'h33);
		chk("hit out", 32'h0, {16'h0, sp_out});
		chk("zero released", 32'h0, {31'h0, zinh});
		acc(0, 12'h008, 0, 32'h1, 0);
		acc(0, 12'h004, 0, 32'h0, 0);
		acc(1, 12'h280, 32'h32, 0, 0);
		acc(0, 12'h008, 0, 32'h0, 0);
		acc(1, 12'h00C, 32'h1, 0, 0);
		smp(1, 24'h0, 24'h33);
		acc(0, 12'h008, 0, 32'h1, 0);
		acc(1, 12'h00C, 32'h1, 0, 0);
		acc(0, 12'h008, 0, 32'h0, 0);
		acc(0, 12'h004, 0, 32'h1, 0);
		acc(1, 12'h010, 32'h1, 0, 0);
		@(negedge clk);
		chk("cancel out", 32'h0, {16'h0, sp_out});
		acc(0, 12'h004, 0, 32'h0, 0);
		acc(0, 12'h020, 0, 32'h0, 1);
	endtask

	initial begin
		n_mismatch = 0;
		compares = 0;
		rst_n = 1'b0;
		scl = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		lvl_hyst();
		lvl_src();
		setp();
		end_of_test();
	end
endmodule
